// ==== core/cmpl_ctrl.v ====
// Digital control for a dual comparator with SR latch and reference select.
// Assumes analog comparators outside; their raw outputs arrive async.
//
// Functional notes
// R1 - Comparator-two control: eight bits, enable down to channel select.
// R2 - Polarity 0 gives result 1 when positive exceeds negative; 1 inverts.
// R3 - Comparator-two pin driven only if pin enable, enable set, direction 0.
// R4 - Reference select routes positive input to internal ref, else pin.
// R5 - Channel select picks negative input 0 to 3 for codes 00 to 11.
// R6 - Latch config bit 7 puts latch output on comparator-two pin.
// R7 - Latch config bit 6 puts latch Q on comparator-one pin.
// R8 - Set enable lets high comparator-one output set the latch.
// R9 - Reset enable lets high comparator-two output reset the latch.
// R10 - Pulse set and reset bits fire one pulse, self clear, zero ignored.
// R11 - Software sets pin enable and direction for latch output on pins.
// R12 - Fixed reference on when its bit is set or fast oscillator runs.
// R13 - Comparator-one divider enable turns on divider and selects it.
// R14 - Comparator-two divider enable turns on divider and selects it.
// R15 - Divider current is the OR of both divider enables.
// R16 - Software waits a settling delay after enabling the fixed reference.
// R17 - All control bits clear on reset.
`timescale 1ns/1ns
`include "cmpl_defs.vh"

module cmpl_ctrl #(
  parameter AW = 4
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_cmp1_raw,
  input wire i_cmp2_raw,
  input wire i_cmp1_polarity,
  input wire i_cmp1_enable,
  input wire i_cmp1_pin_output_enable,
  input wire i_cmp1_port_direction_bit,
  input wire i_cmp2_port_direction_bit,
  input wire i_fast_internal_oscillator,
  output reg o_cmp2_enable,
  output reg o_cmp2_reference_select,
  output reg [1:0] o_cmp2_channel_select,
  output reg o_cmp1_result_pin,
  output reg o_cmp1_pin_oe,
  output reg o_cmp2_result_pin,
  output reg o_cmp2_pin_oe,
  output reg o_fixed_reference_enable,
  output reg o_divider_current_enable,
  output reg o_cmp1_divider_select,
  output reg o_cmp2_divider_select
);

////////////////////////////////////////////////////////////////////////
// Control registers

reg cmp2_enable;
reg cmp2_pin_output_enable;
reg cmp2_polarity;
reg cmp2_reference_select;
reg [1:0] cmp2_channel_select;
reg latch_config_pin_two;
reg latch_config_pin_one;
reg cmp1_latch_set_enable;
reg cmp2_latch_reset_enable;
reg latch_pulse_set;
reg latch_pulse_reset;
reg cmp1_divider_reference_enable;
reg cmp2_divider_reference_enable;
reg fixed_reference_enable;

////////////////////////////////////////////////////////////////////////
// Shared decoding

// Address match for the write decode
function addr_is;
  input [AW-1:0] addr;
  input [AW-1:0] offset;
  begin
    addr_is = (addr == offset);
  end
endfunction

// Pin driver gate: pin enable, comparator on, direction bit at output
function pin_gate;
  input oe;
  input en;
  input dir;
  begin
    pin_gate = oe & en & ~dir;
  end
endfunction

// Polarity on the synchronised level; an idle comparator reads zero
function cmp_result;
  input en;
  input raw;
  input pol;
  begin
    cmp_result = en & (raw ^ pol);
  end
endfunction

// Pin source: latch level when the latch owns the pin, else the result
function pin_source;
  input sel;
  input latched;
  input direct;
  begin
    pin_source = sel ? latched : direct;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Register writes

wire wr_cmp2 = i_wr && addr_is(i_addr, `CMPL_ADDR_CMP2);
wire wr_srl = i_wr && addr_is(i_addr, `CMPL_ADDR_SRL);
wire wr_ref = i_wr && addr_is(i_addr, `CMPL_ADDR_REF);

// Next register values: hold unless the register is written; pulse bits clear
reg next_cmp2_enable;
reg next_cmp2_pin_output_enable;
reg next_cmp2_polarity;
reg next_cmp2_reference_select;
reg [1:0] next_cmp2_channel_select;
reg next_latch_config_pin_two;
reg next_latch_config_pin_one;
reg next_cmp1_latch_set_enable;
reg next_cmp2_latch_reset_enable;
reg next_latch_pulse_set;
reg next_latch_pulse_reset;
reg next_cmp1_divider_reference_enable;
reg next_cmp2_divider_reference_enable;
reg next_fixed_reference_enable;

always @* begin
  next_cmp2_enable = cmp2_enable;
  next_cmp2_pin_output_enable = cmp2_pin_output_enable;
  next_cmp2_polarity = cmp2_polarity;
  next_cmp2_reference_select = cmp2_reference_select;
  next_cmp2_channel_select = cmp2_channel_select;
  next_latch_config_pin_two = latch_config_pin_two;
  next_latch_config_pin_one = latch_config_pin_one;
  next_cmp1_latch_set_enable = cmp1_latch_set_enable;
  next_cmp2_latch_reset_enable = cmp2_latch_reset_enable;
  next_cmp1_divider_reference_enable = cmp1_divider_reference_enable;
  next_cmp2_divider_reference_enable = cmp2_divider_reference_enable;
  next_fixed_reference_enable = fixed_reference_enable;
  // Pulse bits live one cycle only; a written zero does nothing
  next_latch_pulse_set = wr_srl && i_wdata[`CMPL_SR_PSET]; // R10
  next_latch_pulse_reset = wr_srl && i_wdata[`CMPL_SR_PRST]; // R10
  if (wr_cmp2) begin // R1
    next_cmp2_enable = i_wdata[`CMPL_C2_EN];
    next_cmp2_pin_output_enable = i_wdata[`CMPL_C2_OE];
    next_cmp2_polarity = i_wdata[`CMPL_C2_POL];
    next_cmp2_reference_select = i_wdata[`CMPL_C2_RSEL];
    next_cmp2_channel_select = i_wdata[`CMPL_C2_CH_HI:`CMPL_C2_CH_LO];
  end
  if (wr_srl) begin
    next_latch_config_pin_two = i_wdata[`CMPL_SR_PIN2];
    next_latch_config_pin_one = i_wdata[`CMPL_SR_PIN1];
    next_cmp1_latch_set_enable = i_wdata[`CMPL_SR_C1SET];
    next_cmp2_latch_reset_enable = i_wdata[`CMPL_SR_C2RST];
  end
  if (wr_ref) begin
    next_cmp1_divider_reference_enable = i_wdata[`CMPL_RF_C1DIV];
    next_cmp2_divider_reference_enable = i_wdata[`CMPL_RF_C2DIV];
    next_fixed_reference_enable = i_wdata[`CMPL_RF_FIXED];
  end
end

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    cmp2_enable <= 1'b0; // R17
    cmp2_pin_output_enable <= 1'b0;
    cmp2_polarity <= 1'b0;
    cmp2_reference_select <= 1'b0;
    cmp2_channel_select <= 2'h0;
    latch_config_pin_two <= 1'b0;
    latch_config_pin_one <= 1'b0;
    cmp1_latch_set_enable <= 1'b0;
    cmp2_latch_reset_enable <= 1'b0;
    latch_pulse_set <= 1'b0;
    latch_pulse_reset <= 1'b0;
    cmp1_divider_reference_enable <= 1'b0;
    cmp2_divider_reference_enable <= 1'b0;
    fixed_reference_enable <= 1'b0;
  end else begin
    cmp2_enable <= next_cmp2_enable;
    cmp2_pin_output_enable <= next_cmp2_pin_output_enable;
    cmp2_polarity <= next_cmp2_polarity;
    cmp2_reference_select <= next_cmp2_reference_select;
    cmp2_channel_select <= next_cmp2_channel_select;
    latch_config_pin_two <= next_latch_config_pin_two;
    latch_config_pin_one <= next_latch_config_pin_one;
    cmp1_latch_set_enable <= next_cmp1_latch_set_enable;
    cmp2_latch_reset_enable <= next_cmp2_latch_reset_enable;
    latch_pulse_set <= next_latch_pulse_set;
    latch_pulse_reset <= next_latch_pulse_reset;
    cmp1_divider_reference_enable <= next_cmp1_divider_reference_enable;
    cmp2_divider_reference_enable <= next_cmp2_divider_reference_enable;
    fixed_reference_enable <= next_fixed_reference_enable;
  end
end

////////////////////////////////////////////////////////////////////////
// Input synchronisers: change accepted when stages two and three agree

// Costs about four cycles of latency; results are slow analog levels
// anyway, so filtering was preferred over speed.
localparam NSYNC = 2;

wire [NSYNC-1:0] raw_pin = {i_cmp2_raw, i_cmp1_raw};
wire [NSYNC-1:0] raw_ok;

genvar g;
generate
  for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
    reg [2:0] stages;
    reg level;
    always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
        stages <= 3'h0;
        level <= 1'b0;
      end else begin
        stages <= {stages[1:0], raw_pin[g]};
        // A lone glitch in stage two never reaches the level
        if (stages[1] == stages[2])
          level <= stages[2];
      end
    end
    assign raw_ok[g] = level;
  end
endgenerate

wire c1_raw = raw_ok[0];
wire c2_raw = raw_ok[1];

////////////////////////////////////////////////////////////////////////
// Comparator results and SR latch

// Disabled comparator reads as zero
wire cmp2_result = cmp_result(cmp2_enable, c2_raw, cmp2_polarity); // R2
wire cmp1_result = cmp_result(i_cmp1_enable, c1_raw, i_cmp1_polarity);

wire latch_set = latch_pulse_set |
  (cmp1_latch_set_enable & cmp1_result); // R8
wire latch_rst = latch_pulse_reset |
  (cmp2_latch_reset_enable & cmp2_result); // R9

reg latch_q;

// Reset wins when both sides are active, keeping Q at a known level
always @(posedge i_sys_clk) begin
  if (!i_rst_n)
    latch_q <= 1'b0;
  else if (latch_rst)
    latch_q <= 1'b0;
  else if (latch_set)
    latch_q <= 1'b1;
end

////////////////////////////////////////////////////////////////////////
// Pins and analog controls

wire next_c2_pin = pin_source(latch_config_pin_two, ~latch_q,
  cmp2_result); // R6
wire next_c1_pin = pin_source(latch_config_pin_one, latch_q,
  cmp1_result); // R7
wire divider_on = cmp1_divider_reference_enable |
  cmp2_divider_reference_enable; // R15
// Latch reaches a pin only through the normal pin gating
wire next_c1_oe = pin_gate(i_cmp1_pin_output_enable, i_cmp1_enable,
  i_cmp1_port_direction_bit); // R11
wire next_c2_oe = pin_gate(cmp2_pin_output_enable, cmp2_enable,
  i_cmp2_port_direction_bit); // R3
wire next_fixed_ref = fixed_reference_enable |
  i_fast_internal_oscillator; // R12

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    o_cmp2_enable <= 1'b0;
    o_cmp2_reference_select <= 1'b0;
    o_cmp2_channel_select <= 2'h0;
    o_cmp1_result_pin <= 1'b0;
    o_cmp1_pin_oe <= 1'b0;
    o_cmp2_result_pin <= 1'b0;
    o_cmp2_pin_oe <= 1'b0;
    o_fixed_reference_enable <= 1'b0;
    o_divider_current_enable <= 1'b0;
    o_cmp1_divider_select <= 1'b0;
    o_cmp2_divider_select <= 1'b0;
  end else begin
    o_cmp2_enable <= cmp2_enable;
    o_cmp2_reference_select <= cmp2_reference_select; // R4
    o_cmp2_channel_select <= cmp2_channel_select; // R5
    o_cmp1_result_pin <= next_c1_pin;
    o_cmp2_result_pin <= next_c2_pin;
    o_cmp1_pin_oe <= next_c1_oe;
    o_cmp2_pin_oe <= next_c2_oe;
    o_fixed_reference_enable <= next_fixed_ref;
    o_divider_current_enable <= divider_on;
    o_cmp1_divider_select <= cmp1_divider_reference_enable; // R13
    o_cmp2_divider_select <= cmp2_divider_reference_enable; // R14
  end
end

////////////////////////////////////////////////////////////////////////
// Read port: data one cycle after the strobe, zero elsewhere

reg [7:0] next_rdata;

// A strobe to a hole, or no strobe at all, gives zero
always @* begin
  next_rdata = `CMPL_RST_BYTE;
  if (i_rd) begin
    case (i_addr)
      `CMPL_ADDR_CMP2:
        next_rdata = {cmp2_enable, cmp2_result, cmp2_pin_output_enable,
          cmp2_polarity, 1'b0, cmp2_reference_select,
          cmp2_channel_select}; // R1
      `CMPL_ADDR_SRL:
        // Pulse bits always read zero
        next_rdata = {latch_config_pin_two, latch_config_pin_one,
          cmp1_latch_set_enable, cmp2_latch_reset_enable, 4'h0};
      `CMPL_ADDR_REF:
        next_rdata = {cmp1_divider_reference_enable,
          cmp2_divider_reference_enable, 1'b0, fixed_reference_enable,
          4'h0};
      `CMPL_ADDR_STAT:
        next_rdata = {5'h00, c2_raw, cmp1_result, latch_q};
      default:
        next_rdata = `CMPL_RST_BYTE;
    endcase
  end
end

always @(posedge i_sys_clk) begin
  if (!i_rst_n)
    o_rdata <= `CMPL_RST_BYTE;
  else
    o_rdata <= next_rdata;
end

endmodule // cmpl_ctrl

// ==== core/cmpl_defs.vh ====
// Register map and field layout of the comparator and SR latch control.
// Included by the control core; definitions only.
`ifndef CMPL_DEFS_VH
`define CMPL_DEFS_VH

// Register offsets (chosen, no documented address)
`define CMPL_ADDR_CMP2 4'h0
`define CMPL_ADDR_SRL 4'h1
`define CMPL_ADDR_REF 4'h2
`define CMPL_ADDR_STAT 4'h3

// comparator_two_control fields
`define CMPL_C2_EN 7
`define CMPL_C2_RES 6
`define CMPL_C2_OE 5
`define CMPL_C2_POL 4
`define CMPL_C2_RSEL 2
`define CMPL_C2_CH_HI 1
`define CMPL_C2_CH_LO 0

// sr_latch_control fields
`define CMPL_SR_PIN2 7
`define CMPL_SR_PIN1 6
`define CMPL_SR_C1SET 5
`define CMPL_SR_C2RST 4
`define CMPL_SR_PSET 3
`define CMPL_SR_PRST 2

// reference_control_register fields
`define CMPL_RF_C1DIV 7
`define CMPL_RF_C2DIV 6
`define CMPL_RF_FIXED 4

// Status register fields
`define CMPL_ST_Q 0
`define CMPL_ST_C1 1
`define CMPL_ST_C2RAW 2

// Reset values
`define CMPL_RST_BYTE 8'h00

`endif

// ==== sim/cmpl_analog_model.sv ====
// Behavioural comparators and reference muxes in front of the control core.
// Levels are unsigned codes; the core's select outputs steer them.
`timescale 1ns/1ns
module cmpl_analog_model #(
  parameter logic [7:0] DIV_LVL = 8'h80,
  parameter logic [7:0] FIX_LVL = 8'h26
) (
  input wire logic [7:0] i_v1,
  input wire logic [7:0] i_vpin,
  input wire logic [31:0] i_vneg,
  input wire logic i_div1,
  input wire logic i_div2,
  input wire logic i_refsel,
  input wire logic [1:0] i_ch,
  output logic o_raw1,
  output logic o_raw2
);
  logic [7:0] ref1, ref2, pos2;
  assign ref1 = i_div1 ? DIV_LVL : FIX_LVL;
  assign ref2 = i_div2 ? DIV_LVL : FIX_LVL;
  assign pos2 = i_refsel ? ref2 : i_vpin;
  assign o_raw1 = i_v1 > ref1;
  assign o_raw2 = pos2 > i_vneg[i_ch*8 +: 8];
endmodule // cmpl_analog_model

// ==== sim/cmpl_ctrl_sva.sv ====
// Port checker for the comparator control core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module cmpl_ctrl_sva (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_cmp1_enable,
  input wire i_cmp1_pin_output_enable,
  input wire i_cmp1_port_direction_bit,
  input wire i_cmp2_port_direction_bit,
  input wire i_fast_internal_oscillator,
  input wire o_cmp2_enable,
  input wire [1:0] o_cmp2_channel_select,
  input wire o_cmp1_result_pin,
  input wire o_cmp1_pin_oe,
  input wire o_cmp2_result_pin,
  input wire o_cmp2_pin_oe,
  input wire o_fixed_reference_enable,
  input wire o_divider_current_enable,
  input wire o_cmp1_divider_select,
  input wire o_cmp2_divider_select
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////////
  fixed_ref_on_a: assert property (
    i_fast_internal_oscillator |=> o_fixed_reference_enable)
    else $error("fixed reference off while oscillator runs");
  div_current_or_a: assert property (
    o_divider_current_enable ==
      (o_cmp1_divider_select | o_cmp2_divider_select))
    else $error("divider current is not the OR of the selects");
  cmp1_pin_gate_a: assert property (
    1'b1 |=> o_cmp1_pin_oe == $past(i_cmp1_pin_output_enable &
      i_cmp1_enable & !i_cmp1_port_direction_bit))
    else $error("comparator one pin enable wrong");
  cmp2_dir_gate_a: assert property (
    i_cmp2_port_direction_bit |=> !o_cmp2_pin_oe)
    else $error("comparator two pin driven while input");
  cmp2_en_gate_a: assert property (
    !o_cmp2_enable |-> !o_cmp2_pin_oe)
    else $error("comparator two pin driven while disabled");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  // Derived copies may lag the register by one stage
  enable_hold_a: assert property (
    !$past(i_wr) && !$past(i_wr, 2) |-> $stable(o_cmp2_enable))
    else $error("enable changed without a write");
  channel_hold_a: assert property (
    !$past(i_wr) && !$past(i_wr, 2) |-> $stable(o_cmp2_channel_select))
    else $error("channel changed without a write");
  reset_clear_a: assert property (
    $rose(i_rst_n) |-> !(o_cmp2_enable | o_cmp1_pin_oe | o_cmp2_pin_oe |
      o_divider_current_enable | o_cmp1_result_pin | o_cmp2_result_pin |
      o_fixed_reference_enable | (|o_cmp2_channel_select)))
    else $error("outputs not clear after reset");
  latch_pin_c: cover property (o_cmp1_result_pin && !o_cmp2_result_pin);
  pin_drive_c: cover property (o_cmp2_pin_oe);
  div_on_c: cover property ($rose(o_divider_current_enable));
endmodule // cmpl_ctrl_sva
bind cmpl_ctrl cmpl_ctrl_sva u_sva (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench for the comparator control core with analog model.
// Register port master, random levels and settings, latch corner cases.
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] DIV_LVL = 8'h80;
  localparam logic [7:0] FIX_LVL = 8'h26;
  logic i_sys_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, raw1, raw2;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, v1 = 8'h00, vpin = 8'h00, w, r;
  logic [31:0] vneg = 32'h0, seed = 32'h1a43c29e;
  logic osc = 0, dir1 = 0, dir2 = 0, oe1 = 0, pol1 = 0, en1 = 1, res, raw;
  logic [10:0] steps [6];
  int err_total = 0, n_checks = 0;
  wire [7:0] rdata;
  wire [1:0] ch;
  wire c2en, rsel, p1, oe1o, p2, oe2, fix, divc, d1, d2;
  cmpl_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_cmp1_raw(raw1), .i_cmp2_raw(raw2),
    .i_cmp1_polarity(pol1), .i_cmp1_enable(en1),
    .i_cmp1_pin_output_enable(oe1), .i_cmp1_port_direction_bit(dir1),
    .i_cmp2_port_direction_bit(dir2), .i_fast_internal_oscillator(osc),
    .o_cmp2_enable(c2en), .o_cmp2_reference_select(rsel),
    .o_cmp2_channel_select(ch), .o_cmp1_result_pin(p1),
    .o_cmp1_pin_oe(oe1o), .o_cmp2_result_pin(p2), .o_cmp2_pin_oe(oe2),
    .o_fixed_reference_enable(fix), .o_divider_current_enable(divc),
    .o_cmp1_divider_select(d1), .o_cmp2_divider_select(d2));
  cmpl_analog_model u_ana (.i_v1(v1), .i_vpin(vpin), .i_vneg(vneg),
    .i_div1(d1), .i_div2(d2), .i_refsel(rsel), .i_ch(ch),
    .o_raw1(raw1), .o_raw2(raw2));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic do_reset;
    v1 <= 8'h00;
    vpin <= 8'h00;
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
  endtask
  task automatic summarize;
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Comparator two's raw output, with its positive input routed as the selects should route it
  function automatic logic exp_raw(input logic [7:0] wv, input logic dv);
    logic [7:0] pos;
    pos = wv[2] ? (dv ? DIV_LVL : FIX_LVL) : vpin;
    return pos > vneg[wv[1:0]*8 +: 8];
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    do_reset();
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    for (int i = 0; i < 24; i++) begin
      w = 8'($random(seed));
      r = 8'($random(seed)) & 8'hd0;
      vpin <= 8'($random(seed));
      vneg <= $random(seed);
      {osc, dir1, dir2, oe1, pol1, en1} <= 6'($random(seed));
      wr(4'h2, r);
      wr(4'h0, w);
      repeat (10) @(posedge i_sys_clk);
      raw = exp_raw(w, r[6]);
      res = w[7] & (raw ^ w[4]);
      rd(4'h0, {w[7], res, w[5:4], 1'b0, w[2:0]});
      rd(4'h3, {5'h0, raw, en1 & pol1, 1'b0});
      chk({oe2, fix, divc, ch, p2, rsel, oe1o}, {w[5] & w[7] & ~dir2,
        r[4] | osc, r[7] | r[6], w[1:0], res, w[2],
        oe1 & en1 & ~dir1});
      chk({4'h0, p1, c2en, d1, d2},
        {4'h0, en1 & pol1, w[7], r[7], r[6]});
    end
    {pol1, en1} <= 2'b01;
    wr(4'h2, 8'h00);
    vneg <= 32'h40404040;
    wr(4'h0, 8'h80);
    // Each step: latch control byte, cmp1 high, cmp2 high, expected Q
    steps = '{11'h641, 11'h620, 11'h604, 11'h705, 11'h682, 11'h643};
    foreach (steps[k]) begin
      v1 <= steps[k][2] ? 8'hff : 8'h00;
      vpin <= steps[k][1] ? 8'hff : 8'h00;
      repeat (8) @(posedge i_sys_clk);
      wr(4'h1, steps[k][10:3]);
      repeat (8) @(posedge i_sys_clk);
      rd(4'h3, {5'h0, steps[k][1], steps[k][2], steps[k][0]});
      rd(4'h1, steps[k][10:3] & 8'hf0);
      chk({6'h0, p1, p2}, {6'h0, steps[k][0], ~steps[k][0]});
    end
    do_reset();
    summarize();
  end
endmodule // tb_top
